//--- core/bdma_addr.sv
// Banked data memory address generation with bank pointer and GPR bank.
// Assumes the core supplies the quarter phase, decoded instruction fields,
// and an external SFR read path for F80h..FFFh.
//
// Overview of operation
// - Sixteen banks of 256 bytes, 12-bit address
// - Bank address is pointer plus operand offset
// - Only pointer bits 3:0 exist, rest zero
// - Literal load instruction writes bank pointer
// - Unimplemented bank: writes dropped, reads zero
// - Status flags update despite unimplemented bank
// - Full-address move bypasses bank pointer
// - Select bit one uses bank pointer
// - Select bit zero uses quick-access map
// - Quick map: low bank0, high bank15
// - Quick access completes in one cycle
// - GPR contents never cleared by reset
// - Special registers sit at F80h to FFFh
// - Unused special locations read as zero
// - Extended set mapping handled elsewhere
// - Only bank zero GPR implemented
// - Read in Q2, write in Q4
`timescale 1ns/1ns
`default_nettype none
module bdma_addr (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [1:0]  qphase_i,
    input  wire logic        instr_valid_i,
    input  wire logic [7:0]  operand_ofs_i,
    input  wire logic        access_sel_i,
    input  wire logic        full_move_i,
    input  wire logic [11:0] full_addr_i,
    input  wire logic        load_bank_literal_instr_i,
    input  wire logic [7:0]  literal_i,
    input  wire logic        extended_isa_config_bit_i,
    input  wire logic        rd_req_i,
    input  wire logic        wr_req_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        sfr_impl_i,
    input  wire logic [7:0]  sfr_rdata_i,
    output logic      [11:0] mem_addr_o,
    output logic      [7:0]  rdata_o,
    output logic             rd_strobe_o,
    output logic             wr_strobe_o,
    output logic      [3:0]  bank_pointer_o,
    output logic             status_upd_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [3:0]  bank_pointer_r;
    logic [11:0] addr_r;
    logic [7:0]  rdata_r;
    logic        rd_strobe_r;
    logic        wr_strobe_r;
    logic        status_upd_r;

    // Pure function for the access map; only the address path calls it
    function automatic logic [11:0] map_addr(input logic a, input logic [3:0] bp,
                                             input logic [7:0] ofs);
        if (!a) begin
            map_addr = (ofs < bdma_pkg::ACC_SPLIT) ? {bdma_pkg::ACC_LO_BANK, ofs}
                                                   : {bdma_pkg::ACC_HI_BANK, ofs};
        end else begin
            map_addr = {bp, ofs};
        end
    endfunction : map_addr

    ////////////////////////////////////////////////////////////////////////
    // one-cycle address, full move bypass, std map only
    wire [11:0] addr_nxt = full_move_i ? full_addr_i
                                       : map_addr(access_sel_i, bank_pointer_r,
                                                  operand_ofs_i);
    // bank number is top four bits
    wire [3:0]  bank_sel = addr_nxt[11:8];
    wire        in_gpr   = (bank_sel == bdma_pkg::ACC_LO_BANK);
    wire        in_sfr   = (addr_nxt >= bdma_pkg::SFR_BASE);
    wire        is_bp    = (addr_nxt == bdma_pkg::BANK_PTR_ADDR);
    wire        rd_go    = instr_valid_i && rd_req_i && (qphase_i == bdma_pkg::Q2);
    wire        wr_go    = instr_valid_i && wr_req_i && (qphase_i == bdma_pkg::Q4);
    wire        gpr_we   = wr_go && in_gpr;
    wire        bp_we    = wr_go && is_bp;
    wire        lit_we   = instr_valid_i && load_bank_literal_instr_i
                           && (qphase_i == bdma_pkg::Q4);
    wire [7:0]  gpr_rdata;
    wire [7:0]  bp_rdata = {4'h0, bank_pointer_r};
    wire [7:0]  rdata_nxt = in_gpr ? gpr_rdata
                          : is_bp ? bp_rdata
                          : (in_sfr && sfr_impl_i) ? sfr_rdata_i
                          : bdma_pkg::ZERO_BYTE;
    wire [3:0]  bp_nxt   = lit_we ? literal_i[3:0]
                         : bp_we ? wdata_i[3:0]
                         : bank_pointer_r;

    bdma_gpr_ram bdma_gpr_ram_inst (
        .sys_clk_i (sys_clk_i),
        .we_i      (gpr_we),
        .addr_i    (addr_nxt[7:0]),
        .wdata_i   (wdata_i),
        .rdata_o   (gpr_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bank_pointer_r <= bdma_pkg::BANK_PTR_RST[3:0];
            addr_r         <= 12'h000;
            rdata_r        <= 8'h00;
            rd_strobe_r    <= 1'b0;
            wr_strobe_r    <= 1'b0;
            status_upd_r   <= 1'b0;
        end else begin
            bank_pointer_r <= bp_nxt;
            addr_r         <= addr_nxt;
            rd_strobe_r    <= rd_go;
            wr_strobe_r    <= wr_go;
            status_upd_r   <= wr_go;
            if (rd_go) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign mem_addr_o     = addr_r;
    assign rdata_o        = rdata_r;
    assign rd_strobe_o    = rd_strobe_r;
    assign wr_strobe_o    = wr_strobe_r;
    assign bank_pointer_o = bank_pointer_r;
    assign status_upd_o   = status_upd_r;

    ////////////////////////////////////////////////////////////////////////
    sequence s_lit_load;
        lit_we;
    endsequence
    sequence s_ptr_follows;
        ##1 bank_pointer_o == $past(literal_i[3:0]);
    endsequence

    chk_literal_load: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_lit_load |-> s_ptr_follows) else $error("bank pointer missed literal");
    chk_banked_addr: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (!full_move_i && access_sel_i) |=> mem_addr_o == {$past(bank_pointer_r),
                                                          $past(operand_ofs_i)})
        else $error("banked address wrong");
    chk_quick_low: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (!full_move_i && !access_sel_i && !operand_ofs_i[7]) |=> mem_addr_o[11:8] == 4'h0)
        else $error("quick map low half wrong");
    chk_quick_high: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (!full_move_i && !access_sel_i && operand_ofs_i[7]) |=> mem_addr_o[11:8] == 4'hF)
        else $error("quick map high half wrong");
    chk_full_move: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        full_move_i |=> mem_addr_o == $past(full_addr_i)) else $error("full move addr");
    chk_unimpl_read: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (rd_go && !in_gpr && !in_sfr) |=> rdata_o == 8'h00) else $error("missing bank data");
    chk_sfr_hole: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (rd_go && in_sfr && !is_bp && !sfr_impl_i) |=> rdata_o == 8'h00)
        else $error("sfr hole not zero");
    chk_phase_strobe: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        wr_strobe_o |-> $past(qphase_i) == bdma_pkg::Q4) else $error("write off Q4");
    chk_status_upd: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_missing_write |=> status_upd_o)
        else $error("status not updated");

    ////////////////////////////////////////////////////////////////////////
    // These sequences read raw inputs so a slip in the decode wires shows up
    sequence s_missing_write;
        instr_valid_i && wr_req_i && (qphase_i == bdma_pkg::Q4) && !full_move_i
            && access_sel_i && (bank_pointer_r != 4'h0);
    endsequence
    sequence s_ptr_store;
        instr_valid_i && wr_req_i && (qphase_i == bdma_pkg::Q4) && !full_move_i
            && !access_sel_i && (operand_ofs_i == bdma_pkg::BANK_PTR_ADDR[7:0])
            && !load_bank_literal_instr_i;
    endsequence
    sequence s_quick_read;
        instr_valid_i && rd_req_i && (qphase_i == bdma_pkg::Q2) && !full_move_i
            && !access_sel_i;
    endsequence

    chk_missing_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_missing_write |-> !gpr_we)
        else $error("write reached missing bank");
    chk_ptr_store: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ptr_store |=> bank_pointer_o == $past(wdata_i[3:0]))
        else $error("pointer write lost");
    chk_ptr_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !(instr_valid_i && (qphase_i == bdma_pkg::Q4)) |=> $stable(bank_pointer_o))
        else $error("pointer changed unasked");
    chk_ptr_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (rd_go && is_bp) |=> rdata_o == {4'h0, $past(bank_pointer_r)})
        else $error("pointer read wrong");
    chk_quick_one_cycle: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_quick_read |=> rd_strobe_o && (mem_addr_o[7:0] == $past(operand_ofs_i)))
        else $error("quick read not single cycle");
    chk_quick_offset: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (!full_move_i && !access_sel_i) |=> mem_addr_o[7:0] == $past(operand_ofs_i))
        else $error("quick offset wrong");

    chk_read_phase: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        rd_strobe_o |-> $past(qphase_i) == bdma_pkg::Q2)
        else $error("read off Q2");
    chk_read_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (instr_valid_i && rd_req_i && (qphase_i == bdma_pkg::Q2)) |=> rd_strobe_o)
        else $error("read strobe missing");
    chk_write_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (instr_valid_i && wr_req_i && (qphase_i == bdma_pkg::Q4)) |=> wr_strobe_o)
        else $error("write strobe missing");
    chk_status_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !(instr_valid_i && wr_req_i && (qphase_i == bdma_pkg::Q4)) |=> !status_upd_o)
        else $error("status without write");
    chk_sfr_pass: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (rd_go && in_sfr && !is_bp && sfr_impl_i) |=> rdata_o == $past(sfr_rdata_i))
        else $error("sfr data not passed");
    chk_rdata_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !rd_go |=> $stable(rdata_o))
        else $error("read data moved without read");
endmodule : bdma_addr
`default_nettype wire

//--- core/bdma_pkg.sv
// Constants for the banked data memory addressing block.
// Assumes a single core clock; quarter phases come from the core.
package bdma_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          BANK_W        = 4;
    localparam int          OFS_W         = 8;
    localparam int          NUM_BANKS     = 16;
    localparam int          BANK_BYTES    = 256;
    localparam int          GPR_BANKS     = 1;
    localparam logic [11:0] BANK_PTR_ADDR = 12'h0FE0;
    localparam logic [7:0]  BANK_PTR_RST  = 8'h00;
    localparam logic [3:0]  ACC_HI_BANK   = 4'hF;
    localparam logic [3:0]  ACC_LO_BANK   = 4'h0;
    localparam logic [7:0]  ACC_SPLIT     = 8'h80;
    localparam logic [11:0] SFR_BASE      = 12'h0F80;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    localparam logic [7:0]  SFR_HOLES_BASE = 8'h00;
    // Quarter cycle encoding of the core phase input
    localparam logic [1:0]  Q1 = 2'd0;
    localparam logic [1:0]  Q2 = 2'd1;
    localparam logic [1:0]  Q3 = 2'd2;
    localparam logic [1:0]  Q4 = 2'd3;
endpackage : bdma_pkg

//--- core/bdma_gpr_ram.sv
// General-purpose RAM for the one implemented bank.
// Assumes write enable is already qualified by the addressing logic.
`timescale 1ns/1ns
`default_nettype none
module bdma_gpr_ram (
    input  wire logic       sys_clk_i,
    input  wire logic       we_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o
);
    logic [7:0] mem [0:bdma_pkg::BANK_BYTES-1];

    always_ff @(posedge sys_clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[addr_i];
endmodule : bdma_gpr_ram
`default_nettype wire

//--- verif/bdma_core_model.sv
// Core side model: steps the quarter phase of each instruction cycle.
// Assumes the bench drives the decoded instruction fields itself.
`timescale 1ns/1ns
`default_nettype none
module bdma_core_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    output logic      [1:0] qphase_o
);
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            qphase_o <= bdma_pkg::Q1;
        end else begin
            qphase_o <= qphase_o + 2'd1;
        end
    end
endmodule : bdma_core_model
`default_nettype wire

//--- verif/banked_data_memory_addressing_bench.sv
// Bench: quick map, banked, full move and reset retention.
// Assumes the core model owns the quarter phase.
`timescale 1ns/1ns
`default_nettype none
module banked_data_memory_addressing_bench;
    logic        clk, rst_b, iv, sel, fm, le, rd, wr, si, rs, ws, su;
    logic [7:0]  ofs, lit, wd, rdat;
    logic [11:0] fa, addr;
    logic [1:0]  qph;
    logic [3:0]  bp;
    int          failures, check_count;
    ////////////////////////////////////////////////////////////////
    bdma_core_model bdma_core_model_inst (.sys_clk_i(clk), .rst_b_i(rst_b), .qphase_o(qph));
    bdma_addr bdma_addr_inst (.sys_clk_i(clk), .rst_b_i(rst_b), .qphase_i(qph),
        .instr_valid_i(iv), .operand_ofs_i(ofs), .access_sel_i(sel), .full_move_i(fm),
        .full_addr_i(fa), .load_bank_literal_instr_i(le), .literal_i(lit),
        .extended_isa_config_bit_i(1'b0), .rd_req_i(rd), .wr_req_i(wr), .wdata_i(wd),
        .sfr_impl_i(si), .sfr_rdata_i(8'h5A), .mem_addr_o(addr), .rdata_o(rdat),
        .rd_strobe_o(rs), .wr_strobe_o(ws), .bank_pointer_o(bp), .status_upd_o(su));
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("failures=%0d checks=%0d", failures, check_count);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic cmp_addr(input logic [11:0] g, input logic [11:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t addr %h exp %h", $time, g, e);
        end
    endtask : cmp_addr
    task automatic cmp_data(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t data %h exp %h", $time, g, e);
        end
    endtask : cmp_data
    // One access taken at phase ph; strobes judged one edge later
    task automatic op(input logic [1:0] ph, input logic a, input logic [7:0] o,
                      input logic w, input logic [7:0] d, input logic [11:0] ea);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (qph !== ph - 2'd1 && n < 8);
        if (qph !== ph - 2'd1) begin
            failures++;
            close_out();
        end
        iv <= 1'b1;
        sel <= a;
        ofs <= o;
        rd <= !w;
        wr <= w;
        wd <= d;
        @(posedge clk);
        iv <= 1'b0;
        rd <= 1'b0;
        wr <= 1'b0;
        le <= 1'b0;
        fm <= 1'b0;
        @(posedge clk);
        cmp_addr(addr, ea);
        cmp_data({5'h00, ws, su, rs}, {5'h00, w, w, !w && ph == bdma_pkg::Q2});
    endtask : op
    ////////////////////////////////////////////////////////////////
    task automatic sc_quick;
        op(bdma_pkg::Q4, 1'b0, 8'h34, 1'b1, 8'h3C, 12'h034);
        op(bdma_pkg::Q2, 1'b0, 8'h34, 1'b0, 8'h00, 12'h034);
        cmp_data(rdat, 8'h3C);
        op(bdma_pkg::Q2, 1'b0, 8'h90, 1'b0, 8'h00, 12'hF90);
        cmp_data(rdat, 8'h00);
        si <= 1'b1;
        op(bdma_pkg::Q2, 1'b0, 8'h90, 1'b0, 8'h00, 12'hF90);
        cmp_data(rdat, 8'h5A);
        si <= 1'b0;
    endtask : sc_quick
    task automatic sc_bank;
        le <= 1'b1;
        lit <= 8'hA5;
        op(bdma_pkg::Q4, 1'b0, 8'h34, 1'b0, 8'h00, 12'h034);
        cmp_data({4'h0, bp}, 8'h05);
        op(bdma_pkg::Q4, 1'b1, 8'h34, 1'b1, 8'h77, 12'h534);
        op(bdma_pkg::Q2, 1'b1, 8'h34, 1'b0, 8'h00, 12'h534);
        cmp_data(rdat, 8'h00);
        op(bdma_pkg::Q2, 1'b0, 8'h34, 1'b0, 8'h00, 12'h034);
        cmp_data(rdat, 8'h3C);
        op(bdma_pkg::Q4, 1'b0, 8'hE0, 1'b1, 8'hF3, 12'hFE0);
        op(bdma_pkg::Q2, 1'b0, 8'hE0, 1'b0, 8'h00, 12'hFE0);
        cmp_data(rdat, 8'h03);
        le <= 1'b1;
        lit <= 8'h09;
        op(bdma_pkg::Q4, 1'b0, 8'hE0, 1'b1, 8'h0C, 12'hFE0);
        cmp_data({4'h0, bp}, 8'h09);
    endtask : sc_bank
    task automatic sc_full;
        fm <= 1'b1;
        fa <= 12'h034;
        op(bdma_pkg::Q2, 1'b1, 8'hFF, 1'b0, 8'h00, 12'h034);
        cmp_data(rdat, 8'h3C);
        fm <= 1'b1;
        fa <= 12'h056;
        op(bdma_pkg::Q4, 1'b1, 8'hFF, 1'b1, 8'hC3, 12'h056);
        op(bdma_pkg::Q2, 1'b0, 8'h56, 1'b0, 8'h00, 12'h056);
        cmp_data(rdat, 8'hC3);
    endtask : sc_full
    task automatic sc_rerst;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        cmp_data({4'h0, bp}, 8'h00);
        rst_b <= 1'b1;
        op(bdma_pkg::Q2, 1'b0, 8'h34, 1'b0, 8'h00, 12'h034);
        cmp_data(rdat, 8'h3C);
    endtask : sc_rerst
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst_b, iv, sel, fm, le, rd, wr, si} = '0;
        {ofs, lit, wd, fa} = '0;
        failures = 0;
        check_count = 0;
        repeat (12) @(posedge clk);
        cmp_data({4'h0, bp}, 8'h00);
        rst_b <= 1'b1;
        sc_quick();
        sc_bank();
        sc_full();
        sc_rerst();
        close_out();
    end
endmodule : banked_data_memory_addressing_bench
`default_nettype wire
